/* File: inc/pmr_pkg.sv */
// Package: register map, field layout and carriers of the port management registers
package pmr_pkg;
  // -------------------------------------------------------------------------
  // Register indices
  // -------------------------------------------------------------------------
  localparam int          IDX_W          = 5;
  localparam int          DATA_W         = 16;
  localparam int          ADV_W          = 4;
  localparam logic [4:0]  REG_CONTROL    = 5'h00;
  localparam logic [4:0]  REG_STATUS     = 5'h01;
  localparam logic [4:0]  REG_IDENT_UP   = 5'h02;
  localparam logic [4:0]  REG_IDENT_LO   = 5'h03;
  localparam logic [4:0]  REG_ADVERT     = 5'h04;
  localparam logic [4:0]  REG_PARTNER    = 5'h05;
  localparam logic [4:0]  REG_RSVD_1D    = 5'h1D;
  localparam logic [4:0]  REG_SPECIAL    = 5'h1F;
  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int          CTL_FEF_DIS    = 2;
  localparam int          CTL_TX_DIS     = 1;
  localparam int          CTL_LED_DIS    = 0;
  localparam int          ST_AN_DONE     = 5;
  localparam int          ST_FAR_FAULT   = 4;
  localparam int          ST_LINK_UP     = 2;
  localparam int          AB_PAUSE       = 10;
  localparam int          AB_RSVD9       = 9;
  localparam int          AB_TECH_LO     = 5;
  // -------------------------------------------------------------------------
  // Fixed and reset values
  // -------------------------------------------------------------------------
  localparam logic [15:0] STATUS_FIXED   = 16'h7808;
  localparam logic [15:0] STATUS_DYN     = 16'h0034;
  localparam logic [15:0] SELECTOR_CODE  = 16'h0001;
  localparam logic [15:0] ABIL_VAR_MASK  = 16'h07E0;
  localparam logic [2:0]  CTL_RESET      = 3'h0;
  localparam logic        PAUSE_RESET    = 1'h1;
  localparam logic        RSVD9_RESET    = 1'h0;
  localparam logic [3:0]  TECH_RESET     = 4'hF;
  // -------------------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [IDX_W-1:0] index;
    logic [DATA_W-1:0] wdata;
  } pmr_req_t;
  typedef struct packed {
    logic              ack;
    logic              hit;
    logic [DATA_W-1:0] rdata;
  } pmr_rsp_t;
  typedef struct packed {
    logic anDone;
    logic farFault;
    logic linkUp;
  } pmr_phy_t;
  typedef struct packed {
    logic             pause;
    logic [ADV_W-1:0] tech;
  } pmr_abil_t;
  typedef struct packed {
    logic farFaultDisable;
    logic txDisable;
    logic ledDisable;
  } pmr_ctl_t;
endpackage : pmr_pkg

/* File: rtl/pmr_regs.sv */
// Per-port management register bank: control low bits, status, ident, abilities
`timescale 1ns/1ps
module pmr_regs #(
  parameter logic [15:0] IDENT_UPPER = 16'h0A5C, // Arbitrary value
  parameter logic [15:0] IDENT_LOWER = 16'h3C01  // Arbitrary value
) (
  input  wire  logic               clk,
  input  wire  logic               arst_n,
  input  wire  pmr_pkg::pmr_req_t  req,
  output       pmr_pkg::pmr_rsp_t  rsp,
  input  wire  pmr_pkg::pmr_phy_t  phyState,
  input  wire  pmr_pkg::pmr_abil_t partnerAbil,
  output       pmr_pkg::pmr_ctl_t  ctl,
  output       pmr_pkg::pmr_abil_t advert
);
  import pmr_pkg::*;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  // Both front ends translate to this one index space before reaching here
  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    isMapped = (idx <= REG_PARTNER) || (idx == REG_RSVD_1D) ||
               (idx == REG_SPECIAL);
  endfunction : isMapped

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  pmr_ctl_t          ctlQ;
  pmr_ctl_t          next_ctlQ;
  logic              advPause;
  logic              next_advPause;
  logic              advRsvd9;
  logic              next_advRsvd9;
  logic [ADV_W-1:0]  advTech;
  logic [ADV_W-1:0]  next_advTech;
  pmr_phy_t          phyQ;
  pmr_phy_t          next_phyQ;
  pmr_abil_t         partQ;
  pmr_abil_t         next_partQ;
  pmr_rsp_t          rspQ;
  pmr_rsp_t          next_rspQ;
  logic [IDX_W-1:0]  lastIdx;
  logic [IDX_W-1:0]  next_lastIdx;
  logic              lastWrite;
  logic              next_lastWrite;
  logic [DATA_W-1:0] readWord;
  logic              wrEn;

  assign wrEn = req.valid && req.write;

  // -------------------------------------------------------------------------
  // Writable fields
  // -------------------------------------------------------------------------
  always_comb begin
    next_ctlQ     = ctlQ;
    next_advPause = advPause;
    next_advRsvd9 = advRsvd9;
    next_advTech  = advTech;
    if (wrEn && req.index == REG_CONTROL) begin
      next_ctlQ.farFaultDisable = req.wdata[CTL_FEF_DIS];
      next_ctlQ.txDisable       = req.wdata[CTL_TX_DIS];
      next_ctlQ.ledDisable      = req.wdata[CTL_LED_DIS];
    end
    if (wrEn && req.index == REG_ADVERT) begin
      next_advPause = req.wdata[AB_PAUSE];
      next_advRsvd9 = req.wdata[AB_RSVD9];
      next_advTech  = req.wdata[AB_TECH_LO +: ADV_W];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlQ     <= CTL_RESET;
      advPause <= PAUSE_RESET;
      advRsvd9 <= RSVD9_RESET;
      advTech  <= TECH_RESET;
    end else begin
      ctlQ     <= next_ctlQ;
      advPause <= next_advPause;
      advRsvd9 <= next_advRsvd9;
      advTech  <= next_advTech;
    end
  end

  // -------------------------------------------------------------------------
  // Sampled line state
  // -------------------------------------------------------------------------
  // Suppressed detection reports no fault rather than a stale one
  always_comb begin
    next_phyQ          = phyState;
    next_phyQ.farFault = phyState.farFault && !ctlQ.farFaultDisable;
    next_partQ         = partnerAbil;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phyQ  <= '0;
      partQ <= '0;
    end else begin
      phyQ  <= next_phyQ;
      partQ <= next_partQ;
    end
  end

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  // Identifier halves have no storage, so writes cannot disturb them
  always_comb begin
    readWord = '0;
    case (req.index)
      REG_CONTROL: begin
        readWord[CTL_FEF_DIS] = ctlQ.farFaultDisable;
        readWord[CTL_TX_DIS]  = ctlQ.txDisable;
        readWord[CTL_LED_DIS] = ctlQ.ledDisable;
      end
      REG_STATUS: begin
        readWord               = STATUS_FIXED;
        readWord[ST_AN_DONE]   = phyQ.anDone;
        readWord[ST_FAR_FAULT] = phyQ.farFault;
        readWord[ST_LINK_UP]   = phyQ.linkUp;
      end
      REG_IDENT_UP: readWord = IDENT_UPPER;
      REG_IDENT_LO: readWord = IDENT_LOWER;
      REG_ADVERT: begin
        readWord                     = SELECTOR_CODE;
        readWord[AB_PAUSE]           = advPause;
        readWord[AB_RSVD9]           = advRsvd9;
        readWord[AB_TECH_LO +: ADV_W] = advTech;
      end
      REG_PARTNER: begin
        readWord                     = SELECTOR_CODE;
        readWord[AB_PAUSE]           = partQ.pause;
        readWord[AB_TECH_LO +: ADV_W] = partQ.tech;
      end
      default: readWord = '0;
    endcase
  end

  always_comb begin
    next_rspQ     = rspQ;
    next_lastIdx   = lastIdx;
    next_lastWrite = lastWrite;
    next_rspQ.ack  = req.valid;
    if (req.valid) begin
      next_rspQ.hit   = isMapped(req.index);
      next_rspQ.rdata = req.write ? '0 : readWord;
      next_lastIdx    = req.index;
      next_lastWrite  = req.write;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rspQ      <= '0;
      lastIdx   <= '0;
      lastWrite <= 1'b0;
    end else begin
      rspQ      <= next_rspQ;
      lastIdx   <= next_lastIdx;
      lastWrite <= next_lastWrite;
    end
  end

  assign rsp          = rspQ;
  assign ctl          = ctlQ;
  assign advert.pause = advPause;
  assign advert.tech  = advTech;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  logic readAck;
  // Write acks carry no data, so the readback checks judge read acks only
  assign readAck = rspQ.ack && !lastWrite;

  chk_ctrl_write: assert property (@(posedge clk) disable iff (!arst_n)
    wrEn && req.index == REG_CONTROL |=>
      {ctlQ.farFaultDisable, ctlQ.txDisable, ctlQ.ledDisable} ==
      {$past(req.wdata[CTL_FEF_DIS]), $past(req.wdata[CTL_TX_DIS]),
       $past(req.wdata[CTL_LED_DIS])})
    else $error("control low bits not written");

  chk_status_fixed: assert property (@(posedge clk) disable iff (!arst_n)
    readAck && lastIdx == REG_STATUS |->
      (rspQ.rdata & ~STATUS_DYN) == STATUS_FIXED)
    else $error("status fixed bits wrong");

  chk_status_live: assert property (@(posedge clk) disable iff (!arst_n)
    readAck && lastIdx == REG_STATUS |->
      rspQ.rdata[ST_AN_DONE] == $past(phyQ.anDone) &&
      rspQ.rdata[ST_FAR_FAULT] == $past(phyQ.farFault) &&
      rspQ.rdata[ST_LINK_UP] == $past(phyQ.linkUp))
    else $error("status live bits wrong");

  chk_fault_gate: assert property (@(posedge clk) disable iff (!arst_n)
    ctlQ.farFaultDisable && $stable(ctlQ.farFaultDisable) |-> !phyQ.farFault)
    else $error("far fault shown while disabled");

  chk_ident_const: assert property (@(posedge clk) disable iff (!arst_n)
    readAck && lastIdx == REG_IDENT_UP ##1 req.valid && !req.write &&
      req.index == REG_IDENT_LO |=>
      $past(rspQ.rdata, 2) == IDENT_UPPER && rspQ.rdata == IDENT_LOWER)
    else $error("identifier halves wrong");

  chk_adv_write: assert property (@(posedge clk) disable iff (!arst_n)
    wrEn && req.index == REG_ADVERT ##1 req.valid && !req.write &&
      req.index == REG_ADVERT |=>
      rspQ.rdata == (($past(req.wdata, 2) & ABIL_VAR_MASK) | SELECTOR_CODE))
    else $error("advertisement readback wrong");

  chk_partner_read: assert property (@(posedge clk) disable iff (!arst_n)
    readAck && lastIdx == REG_PARTNER |->
      rspQ.rdata == ({5'h00, $past(partQ.pause), 1'h0, $past(partQ.tech), 5'h00}
                     | SELECTOR_CODE))
    else $error("partner ability readback wrong");

  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rspQ.ack && !rspQ.hit |-> rspQ.rdata == '0 && !isMapped(lastIdx))
    else $error("unmapped index not answered as zero");

  chk_ack_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    req.valid |=> rspQ.ack ##0 (lastIdx == $past(req.index)))
    else $error("request not acknowledged in one cycle");
endmodule : pmr_regs

/* File: bench/pmr_station.sv */
// Station manager model issuing single register transfers
`timescale 1ns/1ps
module pmr_station (
  input  wire logic              clk,
  output      pmr_pkg::pmr_req_t req,
  input  wire pmr_pkg::pmr_rsp_t rsp
);
  import pmr_pkg::*;
  initial req = '0;
  // -------------------------------------------------------------------------
  // Transfer
  // -------------------------------------------------------------------------
  // Held for the taking edge only; a longer hold would be taken twice
  task automatic xfer(input logic w, input logic [4:0] i, input logic [15:0] d,
                      output logic [15:0] rd, output logic h, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    h  = 1'b0;
    req <= '{valid: 1'b1, write: w, index: i, wdata: d};
    @(posedge clk);
    // Released lines show inverted values, never the stale ones
    req <= '{valid: 1'b0, write: ~w, index: ~i, wdata: ~d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      if (rsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = rsp.rdata;
        h  = rsp.hit;
      end
    end
  endtask : xfer

  // Two requests on consecutive edges, answers taken at the two edges after
  task automatic xfer_pair(input logic w0, input logic [4:0] i0, input logic [15:0] d0,
                           input logic w1, input logic [4:0] i1, input logic [15:0] d1,
                           output logic [15:0] rd0, output logic [15:0] rd1,
                           output logic ok);
    ok  = 1'b0;
    rd0 = 16'h0000;
    rd1 = 16'h0000;
    req <= '{valid: 1'b1, write: w0, index: i0, wdata: d0};
    @(posedge clk);
    req <= '{valid: 1'b1, write: w1, index: i1, wdata: d1};
    @(posedge clk);
    req <= '{valid: 1'b0, write: ~w1, index: ~i1, wdata: ~d1};
    ok  = (rsp.ack === 1'b1);
    rd0 = rsp.rdata;
    @(posedge clk);
    ok  = ok && (rsp.ack === 1'b1);
    rd1 = rsp.rdata;
  endtask : xfer_pair
endmodule : pmr_station

/* File: bench/pmr_regs_tb.sv */
// Self-checking bench of the port management register bank
`timescale 1ns/1ps
module pmr_regs_tb;
  import pmr_pkg::*;
  localparam logic [15:0] ID_UP = 16'h5A31; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'hC7E2; // Arbitrary value
  logic      clk;
  logic      arst_n;
  pmr_req_t  req;
  pmr_rsp_t  rsp;
  pmr_phy_t  phyState;
  pmr_abil_t partnerAbil;
  pmr_ctl_t  ctl;
  pmr_abil_t advert;
  int        miscompares;
  int        checked;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  pmr_regs #(.IDENT_UPPER(ID_UP), .IDENT_LOWER(ID_LO)) u_dut (
    .clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp), .phyState(phyState),
    .partnerAbil(partnerAbil), .ctl(ctl), .advert(advert));
  pmr_station u_sta (.clk(clk), .req(req), .rsp(rsp));
  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic access(input logic w, input logic [4:0] i, input logic [15:0] d,
                        input logic [15:0] ed, input logic eh);
    logic [15:0] rd;
    logic        h;
    logic        ok;
    u_sta.xfer(w, i, d, rd, h, ok);
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t no acknowledge", $time);
      complete_run();
    end else begin
      check_word({15'h0000, h}, {15'h0000, eh}, "hit");
      check_word(rd, ed, "data");
    end
  endtask : access
  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic test_reset_map();
    check_word({13'h0000, ctl}, 16'h0000, "ctl port");
    check_word({11'h000, advert}, 16'h001F, "advert port");
    access(1'b0, REG_CONTROL, 16'h0000, 16'h0000, 1'b1);
    access(1'b0, REG_STATUS, 16'h0000, 16'h7808, 1'b1);
    access(1'b0, REG_IDENT_UP, 16'h0000, ID_UP, 1'b1);
    access(1'b0, REG_IDENT_LO, 16'h0000, ID_LO, 1'b1);
    access(1'b0, REG_ADVERT, 16'h0000, 16'h05E1, 1'b1);
    access(1'b0, REG_PARTNER, 16'h0000, 16'h0001, 1'b1);
    access(1'b0, REG_RSVD_1D, 16'h0000, 16'h0000, 1'b1);
    access(1'b0, REG_SPECIAL, 16'h0000, 16'h0000, 1'b1);
    access(1'b0, 5'h06, 16'h0000, 16'h0000, 1'b0);
    access(1'b1, 5'h1E, 16'hFFFF, 16'h0000, 1'b0);
    $display("test reset_map done");
  endtask : test_reset_map

  task automatic test_control();
    access(1'b1, REG_CONTROL, 16'hFFFF, 16'h0000, 1'b1);
    access(1'b0, REG_CONTROL, 16'h0000, 16'h0007, 1'b1);
    check_word({13'h0000, ctl}, 16'h0007, "ctl port");
    access(1'b1, REG_CONTROL, 16'h0005, 16'h0000, 1'b1);
    check_word({13'h0000, ctl}, 16'h0005, "ctl port");
    access(1'b1, REG_CONTROL, 16'h0000, 16'h0000, 1'b1);
    $display("test control done");
  endtask : test_control

  task automatic test_status_live();
    phyState <= '{anDone: 1'b1, farFault: 1'b1, linkUp: 1'b1};
    repeat (2) @(posedge clk);
    access(1'b0, REG_STATUS, 16'h0000, 16'h783C, 1'b1);
    access(1'b1, REG_CONTROL, 16'h0004, 16'h0000, 1'b1);
    repeat (2) @(posedge clk);
    access(1'b0, REG_STATUS, 16'h0000, 16'h782C, 1'b1);
    access(1'b1, REG_CONTROL, 16'h0000, 16'h0000, 1'b1);
    // Single bits catch swapped status positions
    phyState <= '{anDone: 1'b1, farFault: 1'b0, linkUp: 1'b0};
    repeat (2) @(posedge clk);
    access(1'b0, REG_STATUS, 16'h0000, 16'h7828, 1'b1);
    phyState <= '{anDone: 1'b0, farFault: 1'b0, linkUp: 1'b1};
    repeat (2) @(posedge clk);
    access(1'b0, REG_STATUS, 16'h0000, 16'h780C, 1'b1);
    phyState <= '0;
    repeat (2) @(posedge clk);
    access(1'b0, REG_STATUS, 16'h0000, 16'h7808, 1'b1);
    $display("test status_live done");
  endtask : test_status_live

  task automatic test_ro_writes();
    access(1'b1, REG_STATUS, 16'hFFFF, 16'h0000, 1'b1);
    access(1'b1, REG_IDENT_UP, 16'hFFFF, 16'h0000, 1'b1);
    access(1'b1, REG_IDENT_LO, 16'hFFFF, 16'h0000, 1'b1);
    access(1'b0, REG_STATUS, 16'h0000, 16'h7808, 1'b1);
    access(1'b0, REG_IDENT_UP, 16'h0000, ID_UP, 1'b1);
    access(1'b0, REG_IDENT_LO, 16'h0000, ID_LO, 1'b1);
    $display("test ro_writes done");
  endtask : test_ro_writes

  task automatic test_back_to_back();
    logic [15:0] rd0;
    logic [15:0] rd1;
    logic        ok;
    u_sta.xfer_pair(1'b0, REG_IDENT_UP, 16'h0000, 1'b0, REG_IDENT_LO, 16'h0000, rd0, rd1, ok);
    check_word({15'h0000, ok}, 16'h0001, "pair ack");
    check_word(rd0, ID_UP, "ident upper");
    check_word(rd1, ID_LO, "ident lower");
    u_sta.xfer_pair(1'b1, REG_ADVERT, 16'h0140, 1'b0, REG_ADVERT, 16'h0000, rd0, rd1, ok);
    check_word({15'h0000, ok}, 16'h0001, "pair ack");
    check_word(rd0, 16'h0000, "advert write data");
    check_word(rd1, 16'h0141, "advert next cycle");
    // Control left set so the later reset has something to clear
    u_sta.xfer_pair(1'b1, REG_CONTROL, 16'hFFFA, 1'b0, REG_CONTROL, 16'h0000, rd0, rd1, ok);
    check_word({15'h0000, ok}, 16'h0001, "pair ack");
    check_word(rd1, 16'h0002, "control next cycle");
    check_word({13'h0000, ctl}, 16'h0002, "ctl port");
    $display("test back_to_back done");
  endtask : test_back_to_back

  task automatic test_advert();
    access(1'b1, REG_ADVERT, 16'hFFFF, 16'h0000, 1'b1);
    access(1'b0, REG_ADVERT, 16'h0000, 16'h07E1, 1'b1);
    access(1'b1, REG_ADVERT, 16'h0000, 16'h0000, 1'b1);
    access(1'b0, REG_ADVERT, 16'h0000, 16'h0001, 1'b1);
    check_word({11'h000, advert}, 16'h0000, "advert port");
    access(1'b1, REG_ADVERT, 16'h0420, 16'h0000, 1'b1);
    access(1'b0, REG_ADVERT, 16'h0000, 16'h0421, 1'b1);
    check_word({11'h000, advert}, 16'h0011, "advert port");
    // Reset in mid-run must restore the writable defaults
    arst_n <= 1'b0;
    @(posedge clk);
    check_word({11'h000, advert}, 16'h001F, "advert after reset");
    check_word({13'h0000, ctl}, 16'h0000, "ctl after reset");
    arst_n <= 1'b1;
    @(posedge clk);
    access(1'b0, REG_ADVERT, 16'h0000, 16'h05E1, 1'b1);
    $display("test advert done");
  endtask : test_advert

  task automatic test_partner();
    partnerAbil <= '{pause: 1'b1, tech: 4'hA};
    repeat (2) @(posedge clk);
    access(1'b0, REG_PARTNER, 16'h0000, 16'h0541, 1'b1);
    access(1'b1, REG_PARTNER, 16'h0000, 16'h0000, 1'b1);
    access(1'b0, REG_PARTNER, 16'h0000, 16'h0541, 1'b1);
    $display("test partner done");
  endtask : test_partner
  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    miscompares = 0;
    checked     = 0;
    arst_n      = 1'b0;
    phyState    = '0;
    partnerAbil = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    test_reset_map();
    test_control();
    test_status_live();
    test_ro_writes();
    test_back_to_back();
    test_advert();
    test_partner();
    complete_run();
  end
endmodule : pmr_regs_tb
